//--- core/ivd_dispatch.sv
/*
 * Interrupt vector dispatch: boots through the reset and mode vectors,
 * then hands the core one vector at a time from traps, software
 * interrupts and peripheral requests, with table address, level and
 * DMA attributes.
 * Assumes the core lowers CORE_READY_IN while it services a vector and
 * that peripheral requests are levels held until serviced.
 */
`timescale 1ns/10ps
module ivd_dispatch
    import ivd_pkg::*;
(
    // Clock and reset
    input  wire logic                        CORE_CLK_IN,
    input  wire logic                        NRST_IN,
    // Core side
    input  wire logic                        CORE_READY_IN,
    input  wire logic [LVL_W-1:0]            ILM_IN,
    input  wire logic [ADDR_W-1:0]           VECTOR_TABLE_BASE_IN,
    input  wire logic [NUM_TRAPS-1:0]        TRAP_REQ_IN,
    input  wire logic                        SW_INT_REQ_IN,
    input  wire logic [VEC_W-1:0]            SW_INT_NUM_IN,
    // Level registers, slot k in bits 5k+4..5k
    input  wire logic [NUM_LVL_REGS*LVL_W-1:0] LEVEL_REGS_IN,
    // Peripheral requests
    input  wire logic [23:0]                 EXT_IRQ_IN,
    input  wire logic [5:0]                  RELOAD_TMR_IRQ_IN,
    input  wire logic [2:0]                  SERIAL_RX_IRQ_IN,
    input  wire logic [2:0]                  SERIAL_TX_IRQ_IN,
    input  wire logic [7:0]                  UART_HI_IRQ_IN,
    input  wire logic                        ADC_IRQ_IN,
    input  wire logic [3:0]                  PULSE_GEN_IRQ_IN,
    input  wire logic                        PULSE_WIDTH_COUNTER_IRQ_IN,
    input  wire logic [1:0]                  REMOTE_CTRL_IRQ_IN,
    input  wire logic                        WATCH_TMR_IRQ_IN,
    input  wire logic                        OSC_WAIT_IRQ_IN,
    input  wire logic                        TIMEBASE_IRQ_IN,
    input  wire logic [4:0]                  DMA_IRQ_IN,
    input  wire logic [3:0]                  MFT_IRQ_IN,
    input  wire logic                        DELAYED_IRQ_IN,
    // Dispatch result
    output logic                             DISPATCH_VALID_OUT,
    output logic [VEC_W-1:0]                 DISPATCH_NUM_OUT,
    output logic [ADDR_W-1:0]                FETCH_ADDR_OUT,
    output ivd_lvl_kind_type                 LEVEL_KIND_OUT,
    output logic [LVL_W-1:0]                 LEVEL_OUT,
    output logic                             RN_VALID_OUT,
    output logic [RN_W-1:0]                  RN_OUT,
    output logic                             DMA_STOP_OUT,
    output logic                             SW_INT_ACK_OUT
);
    // ==============================================================
    // Declarations
    ivd_state_type               state_r;
    ivd_state_type               state_nxt;
    logic [NUM_TRAPS-1:0]        trap_pend_r;
    logic [NUM_TRAPS-1:0]        trap_clr;
    logic [NUM_LVL_REGS-1:0]     periph_req;
    logic                        hw_hit;
    logic [SLOT_W-1:0]           hw_idx;
    logic [LVL_W-1:0]            hw_level;
    logic                        sel_go;
    logic                        sel_sw;
    logic                        sel_hw;
    logic [VEC_W-1:0]            sel_num;
    ivd_lvl_kind_type            attr_kind;
    logic [SLOT_W-1:0]           attr_idx;
    logic                        attr_rn_valid;
    logic [RN_W-1:0]             attr_rn;
    logic                        attr_dma_stop;
    logic [LVL_W-1:0]            sel_level;
    logic                        hw_taken_r;

    // ==============================================================
    // Peripheral slots; a slot number is the vector number minus 16.
    // Merged sources are ORed, so the handler must poll its sources.
    always_comb begin
        periph_req = '0;
        periph_req[SLOT_EXT_LO +: 8]    = EXT_IRQ_IN[7:0];
        periph_req[SLOT_RELOAD_LO +: 3] = RELOAD_TMR_IRQ_IN[2:0];
        for (int c = 0; c < 3; c++) begin
            periph_req[SLOT_SERIAL + 2*c]     = SERIAL_RX_IRQ_IN[c];
            periph_req[SLOT_SERIAL + 2*c + 1] = SERIAL_TX_IRQ_IN[c];
        end
        periph_req[SLOT_UART_HI +: 8]     = UART_HI_IRQ_IN;
        periph_req[SLOT_ADC]              = ADC_IRQ_IN;
        periph_req[SLOT_PULSE_GEN0]       = PULSE_GEN_IRQ_IN[0];
        periph_req[SLOT_PULSE_WIDTH]      = PULSE_WIDTH_COUNTER_IRQ_IN;
        periph_req[SLOT_REMOTE]           = |REMOTE_CTRL_IRQ_IN;
        periph_req[SLOT_WATCH]            = WATCH_TMR_IRQ_IN;
        periph_req[SLOT_OSC_WAIT]         = OSC_WAIT_IRQ_IN;
        periph_req[SLOT_TIMEBASE]         = TIMEBASE_IRQ_IN;
        periph_req[SLOT_RELOAD_HI +: 3]   = RELOAD_TMR_IRQ_IN[5:3];
        periph_req[SLOT_PULSE_GEN_H +: 3] = PULSE_GEN_IRQ_IN[3:1];
        periph_req[SLOT_DMA +: 5]         = DMA_IRQ_IN;
        periph_req[SLOT_EXT_MID]          = |EXT_IRQ_IN[15:8];
        periph_req[SLOT_EXT_TOP]          = |EXT_IRQ_IN[23:16];
        periph_req[SLOT_MFT_LO]           = |MFT_IRQ_IN[1:0];
        periph_req[SLOT_MFT_HI]           = |MFT_IRQ_IN[3:2];
        periph_req[SLOT_DELAYED]          = DELAYED_IRQ_IN;
    end

    // ==============================================================
    // Peripheral arbitration by level register value.
    ivd_prio_pick #(
        .N  (NUM_LVL_REGS),
        .LW (LVL_W),
        .IW (SLOT_W)
    ) u_prio_pick (
        .req_in    (periph_req),
        .levels_in (LEVEL_REGS_IN),
        .hit_out   (hw_hit),
        .idx_out   (hw_idx),
        .level_out (hw_level)
    );

    // ==============================================================
    // Source selection. One dispatch at most every second cycle, which
    // gives the core a cycle to drop its ready before a held request
    // could be taken twice.
    always_comb begin
        sel_go    = 1'b0;
        sel_sw    = 1'b0;
        sel_hw    = 1'b0;
        sel_num   = VEC_RESET;
        trap_clr  = '0;
        state_nxt = state_r;
        if (CORE_READY_IN && !DISPATCH_VALID_OUT) begin
            unique case (state_r)
                ST_BOOT_RESET: begin
                    sel_go    = 1'b1;
                    sel_num   = VEC_RESET;
                    state_nxt = ST_BOOT_MODE;
                end
                ST_BOOT_MODE: begin
                    sel_go    = 1'b1;
                    sel_num   = VEC_MODE;
                    state_nxt = ST_RUN;
                end
                ST_RUN: begin
                    if (|trap_pend_r) begin
                        sel_go = 1'b1;
                        for (int i = NUM_TRAPS - 1; i >= 0; i--) begin
                            if (trap_pend_r[i]) begin
                                sel_num  = TRAP_VEC[i];
                                trap_clr = NUM_TRAPS'(1) << i;
                            end
                        end
                    end else if (SW_INT_REQ_IN && !SW_INT_ACK_OUT) begin
                        sel_go  = 1'b1;
                        sel_sw  = 1'b1;
                        sel_num = SW_INT_NUM_IN;
                    end else if (hw_hit && hw_level < ILM_IN) begin
                        sel_go  = 1'b1;
                        sel_hw  = 1'b1;
                        sel_num = VEC_PERIPH_LO + VEC_W'(hw_idx);
                    end
                end
                default: begin
                    state_nxt = ST_BOOT_RESET;
                end
            endcase
        end
    end

    // ==============================================================
    // Attributes of the chosen vector.
    ivd_vec_attr u_vec_attr (
        .vec_num_in   (sel_num),
        .lvl_kind_out (attr_kind),
        .lvl_idx_out  (attr_idx),
        .rn_valid_out (attr_rn_valid),
        .rn_out       (attr_rn),
        .dma_stop_out (attr_dma_stop)
    );

    // Level value as the core should see it.
    always_comb begin
        unique case (attr_kind)
            LVL_KIND_FIXED: sel_level = LVL_FIXED_VALUE;
            LVL_KIND_REG:   sel_level = LEVEL_REGS_IN[attr_idx*LVL_W +: LVL_W];
            default:        sel_level = LVL_NONE;
        endcase
    end

    // ==============================================================
    // Boot sequence state.
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_r <= ST_BOOT_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Trap pending flags; a new trap in the clearing cycle is kept.
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            trap_pend_r <= '0;
        end else begin
            trap_pend_r <= (trap_pend_r & ~trap_clr) | TRAP_REQ_IN;
        end
    end

    // ==============================================================
    // Registered dispatch outputs.
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            DISPATCH_VALID_OUT <= 1'b0;
            DISPATCH_NUM_OUT   <= '0;
            FETCH_ADDR_OUT     <= '0;
            LEVEL_KIND_OUT     <= LVL_KIND_NONE;
            LEVEL_OUT          <= LVL_NONE;
            RN_VALID_OUT       <= 1'b0;
            RN_OUT             <= '0;
            DMA_STOP_OUT       <= 1'b0;
            SW_INT_ACK_OUT     <= 1'b0;
            hw_taken_r         <= 1'b0;
        end else begin
            DISPATCH_VALID_OUT <= sel_go;
            SW_INT_ACK_OUT     <= sel_sw;
            hw_taken_r         <= sel_hw;
            if (sel_go) begin
                DISPATCH_NUM_OUT <= sel_num;
                FETCH_ADDR_OUT   <= VECTOR_TABLE_BASE_IN + ADDR_W'(
                    VEC_OFFSET_TOP - {sel_num, 2'b00});
                LEVEL_KIND_OUT   <= attr_kind;
                LEVEL_OUT        <= sel_level;
                RN_VALID_OUT     <= attr_rn_valid;
                RN_OUT           <= attr_rn;
                DMA_STOP_OUT     <= attr_dma_stop;
            end
        end
    end

    // ==============================================================
    // Assertions
    // Level registers one cycle back, so that the level check indexes
    // the old values with the vector number that is out now.
    logic [NUM_LVL_REGS*LVL_W-1:0] lvl_regs_past_r;
    always_ff @(posedge CORE_CLK_IN) begin
        lvl_regs_past_r <= LEVEL_REGS_IN;
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    fetch_address_a: assert property (
        DISPATCH_VALID_OUT |-> FETCH_ADDR_OUT ==
            $past(VECTOR_TABLE_BASE_IN) + 32'h3fc
            - 32'(DISPATCH_NUM_OUT) * 4)
        else $error("fetch address does not match vector number");

    reset_vector_a: assert property (
        state_r == ST_BOOT_RESET && CORE_READY_IN && !DISPATCH_VALID_OUT
        |=> DISPATCH_VALID_OUT && DISPATCH_NUM_OUT == 8'h00
            && LEVEL_KIND_OUT == LVL_KIND_NONE ##1 state_r == ST_BOOT_MODE)
        else $error("reset vector not dispatched first");

    mode_vector_a: assert property (
        state_r == ST_BOOT_MODE && CORE_READY_IN && !DISPATCH_VALID_OUT
        |=> DISPATCH_VALID_OUT && DISPATCH_NUM_OUT == 8'h01
            && LEVEL_KIND_OUT == LVL_KIND_NONE)
        else $error("mode vector not dispatched second");

    trap_first_a: assert property (
        state_r == ST_RUN && trap_pend_r[0] && CORE_READY_IN
        && !DISPATCH_VALID_OUT
        |=> DISPATCH_NUM_OUT == 8'h07 && LEVEL_KIND_OUT == LVL_KIND_NONE)
        else $error("missing coprocessor trap not on vector 7");

    trap_kept_a: assert property (
        $rose(TRAP_REQ_IN[5]) && !trap_pend_r[5] |=> trap_pend_r[5])
        else $error("undefined opcode trap lost");

    fixed_level_a: assert property (
        DISPATCH_VALID_OUT && DISPATCH_NUM_OUT == 8'h0f
        |-> LEVEL_KIND_OUT == LVL_KIND_FIXED && LEVEL_OUT == 5'h0f)
        else $error("vector 15 level not fixed at 15");

    periph_level_a: assert property (
        DISPATCH_VALID_OUT && DISPATCH_NUM_OUT inside {[8'h10:8'h3f]}
        |-> LEVEL_KIND_OUT == LVL_KIND_REG && LEVEL_OUT ==
            lvl_regs_past_r[(DISPATCH_NUM_OUT - 8'h10) * 5 +: 5])
        else $error("peripheral level not from its register");

    serial_rx_rn_a: assert property (
        DISPATCH_VALID_OUT && DISPATCH_NUM_OUT inside {8'd27, 8'd29, 8'd31}
        |-> RN_VALID_OUT && DMA_STOP_OUT
            && RN_OUT == 4'((DISPATCH_NUM_OUT - 8'd27) >> 1))
        else $error("serial receive resource number wrong");

    serial_tx_rn_a: assert property (
        DISPATCH_VALID_OUT && DISPATCH_NUM_OUT inside {8'd28, 8'd30, 8'd32}
        |-> RN_VALID_OUT && !DMA_STOP_OUT
            && RN_OUT == 4'(((DISPATCH_NUM_OUT - 8'd28) >> 1) + 8'd3))
        else $error("serial transmit resource number wrong");

    hw_range_a: assert property (
        hw_taken_r |-> DISPATCH_NUM_OUT inside {[8'h10:8'h3f]})
        else $error("hardware request outside vectors 16 to 63");

    swi_only_a: assert property (
        DISPATCH_VALID_OUT && DISPATCH_NUM_OUT >= 8'h50
        |-> SW_INT_ACK_OUT && !RN_VALID_OUT
            && LEVEL_KIND_OUT == LVL_KIND_NONE)
        else $error("high vector dispatched without software request");

    boot_done_c:   cover property (state_r == ST_BOOT_MODE ##[1:8]
                                   state_r == ST_RUN);
    trap_taken_c:  cover property (DISPATCH_VALID_OUT
                                   && DISPATCH_NUM_OUT == 8'h0e);
    sw_taken_c:    cover property (SW_INT_ACK_OUT
                                   && DISPATCH_NUM_OUT >= 8'h50);
    hw_taken_c:    cover property (hw_taken_r && DMA_STOP_OUT);
endmodule // ivd_dispatch

//--- core/ivd_prio_pick.sv
/*
 * Picks the pending request with the lowest level value; on a tie the
 * lowest slot wins. Purely combinational.
 * Assumes levels are packed slot by slot, slot 0 in the low bits.
 */
`timescale 1ns/10ps
module ivd_prio_pick #(
    parameter int N  = 48,
    parameter int LW = 5,
    parameter int IW = 6
) (
    // Requests and their levels
    input  wire logic [N-1:0]    req_in,
    input  wire logic [N*LW-1:0] levels_in,
    // Winner
    output logic                 hit_out,
    output logic [IW-1:0]        idx_out,
    output logic [LW-1:0]        level_out
);
    // ==============================================================
    // Elaboration check
    if (N > (1 << IW) || N < 1) begin : g_bad_width
        $error("ivd_prio_pick: N does not fit in IW bits");
    end

    // ==============================================================
    // Scan from the top so that ties fall to the lower slot.
    always_comb begin
        hit_out   = 1'b0;
        idx_out   = '0;
        level_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i] &&
                (!hit_out || levels_in[i*LW +: LW] <= level_out)) begin
                hit_out   = 1'b1;
                idx_out   = IW'(i);
                level_out = levels_in[i*LW +: LW];
            end
        end
    end
endmodule // ivd_prio_pick

//--- core/ivd_vec_attr.sv
/*
 * Attribute lookup for one vector number: where its level comes from,
 * its DMA resource number and whether it stops DMA. Purely combinational.
 * Assumes the caller registers the results.
 */
`timescale 1ns/10ps
module ivd_vec_attr
    import ivd_pkg::*;
(
    // Lookup key
    input  wire logic [VEC_W-1:0]  vec_num_in,
    // Attributes
    output ivd_lvl_kind_type       lvl_kind_out,
    output logic [SLOT_W-1:0]      lvl_idx_out,
    output logic                   rn_valid_out,
    output logic [RN_W-1:0]        rn_out,
    output logic                   dma_stop_out
);
    // ==============================================================
    // Level source and resource numbers
    // Vectors below 0x0f and from 0x40 up carry no level at all.
    always_comb begin
        lvl_kind_out = LVL_KIND_NONE;
        lvl_idx_out  = '0;
        rn_valid_out = 1'b0;
        rn_out       = '0;
        dma_stop_out = 1'b0;
        if (vec_num_in == VEC_SYS_FIXED) begin
            lvl_kind_out = LVL_KIND_FIXED;
        end else if (vec_num_in >= VEC_PERIPH_LO &&
                     vec_num_in <= VEC_PERIPH_HI) begin
            lvl_kind_out = LVL_KIND_REG;
            lvl_idx_out  = SLOT_W'(vec_num_in - VEC_PERIPH_LO);
        end
        for (int c = 0; c < 3; c++) begin
            if (vec_num_in == VEC_W'(16 + SLOT_SERIAL + 2 * c)) begin
                rn_valid_out = 1'b1;
                rn_out       = RN_SERIAL_RX + RN_W'(c);
                dma_stop_out = 1'b1;
            end
            if (vec_num_in == VEC_W'(17 + SLOT_SERIAL + 2 * c)) begin
                rn_valid_out = 1'b1;
                rn_out       = RN_SERIAL_TX + RN_W'(c);
            end
        end
        if (vec_num_in == VEC_W'(16 + SLOT_PULSE_GEN0)) begin
            rn_valid_out = 1'b1;
            rn_out       = RN_PULSE_GEN;
        end
    end
endmodule // ivd_vec_attr

//--- shared/ivd_pkg.sv
/*
 * Constants, types and vector map of the interrupt vector dispatch block.
 * Assumes a 32-bit core with 256 vectors that are spaced one word apart
 * and counted downward from the top of the table.
 */
package ivd_pkg;
    // ==============================================================
    // Widths and sizes
    localparam int VEC_W        = 8;
    localparam int ADDR_W       = 32;
    localparam int LVL_W        = 5;
    localparam int NUM_LVL_REGS = 48;
    localparam int SLOT_W       = 6;
    localparam int NUM_TRAPS    = 6;
    localparam int RN_W         = 4;

    // ==============================================================
    // Table layout and level values
    localparam logic [9:0]       VEC_OFFSET_TOP  = 10'h3fc;
    localparam logic [LVL_W-1:0] LVL_NONE        = 5'h00;
    localparam logic [LVL_W-1:0] LVL_FIXED_VALUE = 5'h0f;
    localparam logic [LVL_W-1:0] LVL_REG_RESET   = 5'h1f;

    // ==============================================================
    // Vector numbers
    localparam logic [VEC_W-1:0] VEC_RESET     = 8'h00;
    localparam logic [VEC_W-1:0] VEC_MODE      = 8'h01;
    localparam logic [VEC_W-1:0] VEC_SYS_FIXED = 8'h0f;
    localparam logic [VEC_W-1:0] VEC_PERIPH_LO = 8'h10;
    localparam logic [VEC_W-1:0] VEC_PERIPH_HI = 8'h3f;
    localparam logic [VEC_W-1:0] VEC_OS_LO     = 8'h40;
    localparam logic [VEC_W-1:0] VEC_OS_HI     = 8'h41;
    localparam logic [VEC_W-1:0] VEC_SWI_LO    = 8'h50;

    // Trap vectors, lowest number first: missing coprocessor, coprocessor
    // error, emulator break, step trace, tool request, undefined opcode.
    localparam logic [VEC_W-1:0] TRAP_VEC [NUM_TRAPS] =
        '{8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h0e};

    // ==============================================================
    // Peripheral slots; a slot is its vector number minus 0x10
    localparam int SLOT_EXT_LO      = 0;
    localparam int SLOT_RELOAD_LO   = 8;
    localparam int SLOT_SERIAL      = 11;
    localparam int SLOT_UART_HI     = 17;
    localparam int SLOT_ADC         = 25;
    localparam int SLOT_PULSE_GEN0  = 26;
    localparam int SLOT_PULSE_WIDTH = 27;
    localparam int SLOT_REMOTE      = 28;
    localparam int SLOT_WATCH       = 29;
    localparam int SLOT_OSC_WAIT    = 30;
    localparam int SLOT_TIMEBASE    = 31;
    localparam int SLOT_RELOAD_HI   = 32;
    localparam int SLOT_PULSE_GEN_H = 35;
    localparam int SLOT_DMA         = 38;
    localparam int SLOT_EXT_MID     = 43;
    localparam int SLOT_EXT_TOP     = 44;
    localparam int SLOT_MFT_LO      = 45;
    localparam int SLOT_MFT_HI      = 46;
    localparam int SLOT_DELAYED     = 47;

    // ==============================================================
    // DMA resource numbers
    localparam logic [RN_W-1:0] RN_SERIAL_RX = 4'h0;
    localparam logic [RN_W-1:0] RN_SERIAL_TX = 4'h3;
    localparam logic [RN_W-1:0] RN_PULSE_GEN = 4'hc;

    // ==============================================================
    // Types
    typedef enum logic [1:0] {
        LVL_KIND_NONE  = 2'b00,
        LVL_KIND_FIXED = 2'b01,
        LVL_KIND_REG   = 2'b10
    } ivd_lvl_kind_type;

    typedef enum logic [1:0] {
        ST_BOOT_RESET = 2'b00,
        ST_BOOT_MODE  = 2'b01,
        ST_RUN        = 2'b10
    } ivd_state_type;
endpackage

//--- verif/ivd_core_model.sv
/* Behavioural core that takes dispatched vectors.
   Assumes the bench sets the service time per vector. */
`timescale 1ns/10ps
module ivd_core_model (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // Dispatch handshake
    input  wire logic valid_in,
    input  wire logic [31:0] stall_in,
    output logic      ready_out
);
    int cnt_r;
    // ==========================================================
    // Service time: a vector keeps the core busy for a while.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) cnt_r <= 0;
        else if (valid_in) cnt_r <= stall_in;
        else if (cnt_r > 0) cnt_r <= cnt_r - 1;
    end
    // Busy while the pulse stands, so no second take is offered.
    assign ready_out = (cnt_r == 0) && !valid_in;
endmodule // ivd_core_model

//--- verif/test_ivd_dispatch.sv
/* Self-checking bench of the vector dispatch block.
   Assumes the core model is compiled before this file. */
`timescale 1ns/10ps
module test_ivd_dispatch;
    import ivd_pkg::*;
    typedef struct {logic [7:0] n; ivd_lvl_kind_type k; logic [4:0] l;
        logic rv; logic [3:0] rn; logic st; logic ack;} ivd_exp_type;
    logic clk = 0, nrst = 0, ready, sw_req = 0, valid, rnv, stop, ack;
    logic [4:0] ilm = 5'h1f, lvl_o;
    logic [31:0] base = 32'h0, addr;
    logic [5:0] trap = 6'h0;
    logic [7:0] sw_num = 8'h0, num;
    logic [239:0] lvl = '1;
    logic [64:0] src = '0;
    logic [3:0] rn;
    ivd_lvl_kind_type kind;
    ivd_exp_type q[$];
    int err_count = 0, num_checks = 0, seed = 32'hfe29, stall = 0, n, b;
    int sv[3] = '{15, 80, 255};
    int pb[33] = '{0,7,8,15,16,23,24,26,27,29,30,31,32,33,35,36,44,45,46,
        48,49,50,51,52,53,54,55,59,60,61,62,63,64};
    int pv[33] = '{16,23,59,59,60,60,24,26,48,50,27,29,31,28,32,33,41,42,
        51,53,43,44,44,45,46,47,54,58,61,61,62,62,63};
    ivd_dispatch dut_u (.CORE_CLK_IN(clk), .NRST_IN(nrst),
        .CORE_READY_IN(ready), .ILM_IN(ilm), .VECTOR_TABLE_BASE_IN(base),
        .TRAP_REQ_IN(trap), .SW_INT_REQ_IN(sw_req), .SW_INT_NUM_IN(sw_num),
        .LEVEL_REGS_IN(lvl), .EXT_IRQ_IN(src[23:0]),
        .RELOAD_TMR_IRQ_IN(src[29:24]), .SERIAL_RX_IRQ_IN(src[32:30]),
        .SERIAL_TX_IRQ_IN(src[35:33]), .UART_HI_IRQ_IN(src[43:36]),
        .ADC_IRQ_IN(src[44]), .PULSE_GEN_IRQ_IN(src[48:45]),
        .PULSE_WIDTH_COUNTER_IRQ_IN(src[49]), .REMOTE_CTRL_IRQ_IN(src[51:50]),
        .WATCH_TMR_IRQ_IN(src[52]), .OSC_WAIT_IRQ_IN(src[53]),
        .TIMEBASE_IRQ_IN(src[54]), .DMA_IRQ_IN(src[59:55]),
        .MFT_IRQ_IN(src[63:60]), .DELAYED_IRQ_IN(src[64]),
        .DISPATCH_VALID_OUT(valid), .DISPATCH_NUM_OUT(num),
        .FETCH_ADDR_OUT(addr), .LEVEL_KIND_OUT(kind), .LEVEL_OUT(lvl_o),
        .RN_VALID_OUT(rnv), .RN_OUT(rn), .DMA_STOP_OUT(stop),
        .SW_INT_ACK_OUT(ack));
    ivd_core_model core_u (.clk_in(clk), .nrst_in(nrst), .valid_in(valid),
        .stall_in(stall), .ready_out(ready));
    // ==========================================================
    // Clock, watchdog and the shared tasks.
    initial forever #2 clk = ~clk;
    initial begin
        #20000;
        err_count++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ex(int vn, ivd_lvl_kind_type k, logic [4:0] l,
        logic rv, logic [3:0] r, logic st, logic a);
        q.push_back('{8'(vn), k, l, rv, r, st, a});
    endtask
    // Waits for the pulse under a bound, so a lost request cannot hang.
    task automatic wt();
        int c;
        c = 0;
        do begin @(posedge clk); #1 c++; end while (valid !== 1'b1 && c < 50);
        if (c >= 50) begin err_count++; $display("mismatch %0t no pulse", $time); end
    endtask
    task automatic chk(ivd_exp_type e);
        num_checks++;
        if (num !== e.n || kind !== e.k || lvl_o !== e.l || ack !== e.ack ||
            addr !== base + 32'h3fc - {22'h0, e.n, 2'b00} ||
            rnv !== e.rv || (e.rv && rn !== e.rn) || stop !== e.st) begin
            err_count++;
            $display("mismatch %0t vector %0h got %0h", $time, e.n, num);
        end
    endtask
    // Results are read mid-cycle, where the registered outputs have settled.
    always @(negedge clk) if (valid === 1'b1) begin
        if (q.size() == 0) begin err_count++; $display("mismatch %0t extra", $time); end
        else chk(q.pop_front());
    end
    // ==========================================================
    // Main sequence: boot, traps, software, then peripheral sources.
    initial begin
        for (int k = 0; k < 48; k++) lvl[5*k+:5] = 5'({$random(seed)} % 31);
        base = $random(seed);
        ex(0, LVL_KIND_NONE, LVL_NONE, 0, 0, 0, 0);
        ex(1, LVL_KIND_NONE, LVL_NONE, 0, 0, 0, 0);
        repeat (12) @(posedge clk);
        #1 nrst = 1;
        wt();
        wt();
        for (int t = 0; t < 6; t++) begin
            @(posedge clk); #1 stall = {$random(seed)} % 4;
            ex(TRAP_VEC[t], LVL_KIND_NONE, LVL_NONE, 0, 0, 0, 0);
            trap[t] = 1'b1;
            @(posedge clk); #1 trap = 6'h0;
            wt();
        end
        for (int s = 0; s < 3; s++) begin
            @(posedge clk); #1 sw_num = 8'(sv[s]);
            ex(sv[s], sv[s] == 15 ? LVL_KIND_FIXED : LVL_KIND_NONE, sv[s] == 15 ? LVL_FIXED_VALUE : LVL_NONE, 0, 0, 0, 1);
            sw_req = 1'b1;
            wt();
            sw_req = 1'b0;
        end
        for (int i = 0; i < 33; i++) begin
            @(posedge clk); #1 stall = {$random(seed)} % 4;
            n = pv[i];
            b = pb[i];
            ex(n, LVL_KIND_REG, lvl[5*(n-16)+:5], (b >= 30 && b < 36) || b == 45, b == 45 ? 4'hc : 4'(b - 30), b >= 30 && b < 33, 0);
            src[b] = 1'b1;
            wt();
            src[b] = 1'b0;
        end
        // A masked source waits for the mask; then a mid-run reset reboots.
        @(posedge clk); #1 ilm = 5'h00;
        src[52] = 1'b1;
        repeat (8) @(posedge clk);
        #1 ilm = 5'h1f;
        ex(45, LVL_KIND_REG, lvl[145+:5], 0, 0, 0, 0);
        wt();
        src[52] = 1'b0;
        @(posedge clk); #1 nrst = 0;
        ex(0, LVL_KIND_NONE, LVL_NONE, 0, 0, 0, 0);
        ex(1, LVL_KIND_NONE, LVL_NONE, 0, 0, 0, 0);
        @(posedge clk); #1 nrst = 1;
        wt();
        wt();
        repeat (6) @(posedge clk);
        if (q.size() != 0) begin err_count++; $display("mismatch %0t missing", $time); end
        complete_run();
    end
endmodule // test_ivd_dispatch
